/* hw/sync_status_output_control.sv */
// Sync status and output control register bank with output pin control.
// Assumes a serial control port drives the byte register strobes, and
// that clock candidates, video data and field come from on-chip logic.
//
// How it works
// - two-bit field selects which clock drives out
// - output high-impedance bit floats all but green sync
// - green sync high-impedance bit floats green sync pin
// - field polarity bit maps odd/even to level
// - PLL reference is raw or filtered sync
// - sync processor uses raw or regenerated sync
// - window width, 25 ns steps, rejects stray pulses
// - input_activity_status bits 7,6 show horizontal sync activity
// - input_activity_status bits 5,4 show vertical sync activity
// - input_activity_status bits 3,2 show green sync activity
// - input_activity_status bit 1 shows clock/hold pin activity
// - input_activity_status bit 0 shows clamp pin activity
// - input_polarity_status bits 7,6 give horizontal sync polarity
// - input_polarity_status bits 5,4 give vertical sync polarity
// - input_polarity_status bit 3 gives external hold polarity
`include "sync_ctl_consts.svh"

module sync_status_output_control
    import sync_ctl_pkg::*;
#(
    parameter int DW = 30,
    parameter int NSW = 20,
    parameter int CW = 22,
    parameter int TIMEOUT_CYCLES =
        (`ACT_TIMEOUT_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
    parameter logic [7:0] KEEP_A_DEFAULT = `KEEP_A_RESET,
    parameter logic [7:0] KEEP_B_DEFAULT = `KEEP_B_RESET
) (
    input wire logic CLK,                  // 50 MHz internal clock
    input wire logic RST,                  // Synchronous reset
    input wire logic [7:0] REG_ADDR,       // Register offset
    input wire logic REG_WR,               // Write strobe
    input wire logic [7:0] REG_WDATA,      // Write data
    input wire logic REG_RD,               // Read strobe
    output logic [7:0] REG_RDATA,          // Read data, next cycle
    input wire logic PIX_CLK,              // Pixel clock candidate
    input wire logic PIX_CLK_90,           // Shifted pixel clock
    input wire logic PIX_CLK_2X,           // Doubled pixel clock
    input wire logic INT_CLK_40M,          // Fixed internal clock
    output logic CLK_OUT,                  // Selected output clock
    output logic CLK_OUT_OE,               // Clock pin drive enable
    input wire logic [DW-1:0] DATA_IN,     // Formatted pixel data
    output logic [DW-1:0] DATA_OUT,        // Data pins
    output logic DATA_OE,                  // Data pin drive enable
    input wire logic FIELD_IS_ODD,         // Field detector result
    output logic FIELD_OUT,                // Field pin
    output logic FIELD_OE,                 // Field pin drive enable
    input wire logic GREEN_SYNC_SLICED,    // Sliced green sync
    output logic GREEN_SYNC_OUTPUT_PIN,    // Green sync output pin
    output logic GREEN_SYNC_OUTPUT_OE,     // Green sync drive enable
    input wire logic HORIZ_SYNC_IN_CH0,    // Pin
    input wire logic HORIZ_SYNC_IN_CH1,    // Pin
    input wire logic VERT_SYNC_IN_CH0,     // Pin
    input wire logic VERT_SYNC_IN_CH1,     // Pin
    input wire logic GREEN_SYNC_IN_CH0,    // Pin
    input wire logic GREEN_SYNC_IN_CH1,    // Pin
    input wire logic EXT_CLOCK_OR_HOLD_PIN, // Pin
    input wire logic CLAMP_PIN,            // Pin
    input wire logic RAW_SYNC,             // Active-channel sync, async
    output logic PLL_REF_SYNC,             // Sync to the PLL
    output logic SP_SYNC                   // Sync to the sync processor
);

    typedef struct packed {
        logic [`PIN_COUNT-1:0] meta;
        logic [`PIN_COUNT-1:0] pin;
        logic [7:0] ctl;
        logic [7:0] keep_a;
        logic [7:0] keep_b;
        logic [7:0] win;
        logic [7:0] rdata;
        logic [DW-1:0] data;
        logic field;
        logic gsync;
        logic raw_d;
        filt_mode_type mode;
        logic [NSW-1:0] cnt_ns;
        logic [NSW-1:0] period_ns;
        logic filt;
        logic pll_ref;
        logic sp_sync;
    } top_state_type;

    localparam logic [NSW-1:0] STEP_NS = NSW'(`CLK_PERIOD_NS);
    localparam logic [NSW-1:0] WIN_STEP = NSW'(`WIN_STEP_NS);

    top_state_type s_ff, nxt_s;
    logic [`SENSE_COUNT-1:0] act;
    logic [`SENSE_COUNT-1:0] pos;
    logic [7:0] act_status;
    logic [7:0] pol_status;
    logic [NSW-1:0] win_ns;
    logic [NSW:0] near_lo;
    logic [NSW:0] near_hi;
    logic in_window;
    logic late;
    logic raw_rise;
    logic raw_fall;
    logic [`PIN_COUNT-1:0] pins_async;
    clk_sel_type clk_sel;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
        hit = (a == t);
    endfunction

    function automatic logic [7:0] read_mux(input logic [7:0] a,
                                            input top_state_type st,
                                            input logic [7:0] as,
                                            input logic [7:0] ps);
        read_mux = `RD_UNMAPPED;
        if (hit(a, `ADDR_CTL)) begin
            read_mux = st.ctl;
        end
        if (hit(a, `ADDR_KEEP_A)) begin
            read_mux = st.keep_a;
        end
        if (hit(a, `ADDR_KEEP_B)) begin
            read_mux = st.keep_b;
        end
        if (hit(a, `ADDR_WIN)) begin
            read_mux = st.win;
        end
        if (hit(a, `ADDR_ACT)) begin
            read_mux = as;
        end
        if (hit(a, `ADDR_POL)) begin
            read_mux = ps;
        end
    endfunction

    assign pins_async = {RAW_SYNC, HORIZ_SYNC_IN_CH0, HORIZ_SYNC_IN_CH1,
                         VERT_SYNC_IN_CH0, VERT_SYNC_IN_CH1,
                         GREEN_SYNC_IN_CH0, GREEN_SYNC_IN_CH1,
                         EXT_CLOCK_OR_HOLD_PIN, CLAMP_PIN};

    // One sensor per pin except the raw sync; polarity is only reported for some of them
    generate
        for (genvar i = 0; i < `SENSE_COUNT; i++) begin : g_sense
            sync_sense #(
                .CW(CW),
                .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
            ) u_sense (
                .clk(CLK),
                .rst(RST),
                .level(s_ff.pin[i]),
                .active(act[i]),
                .positive(pos[i])
            );
        end
    endgenerate

    assign act_status = act;
    assign pol_status = {pos[`PIN_H0], pos[`PIN_H1],
                         pos[`PIN_V0], pos[`PIN_V1],
                         pos[`PIN_EXT], 3'h0};

    // Window in ns so 25 ns steps need no rounding to 20 ns cycles
    assign win_ns = NSW'(s_ff.win) * WIN_STEP;
    assign near_lo = {1'b0, s_ff.cnt_ns} + {1'b0, win_ns};
    assign near_hi = {1'b0, s_ff.period_ns} + {1'b0, win_ns};
    assign in_window = (near_lo >= {1'b0, s_ff.period_ns}) &&
                       ({1'b0, s_ff.cnt_ns} <= near_hi);
    assign late = {1'b0, s_ff.cnt_ns} > near_hi;
    assign raw_rise = s_ff.pin[`PIN_RAW] & ~s_ff.raw_d;
    assign raw_fall = ~s_ff.pin[`PIN_RAW] & s_ff.raw_d;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.meta = pins_async;
        nxt_s.pin = s_ff.meta;
        nxt_s.raw_d = s_ff.pin[`PIN_RAW];
        if (REG_WR && hit(REG_ADDR, `ADDR_CTL)) begin
            nxt_s.ctl = {REG_WDATA[7:1], 1'b0};
        end
        // Stored and read back only; the far side keeps them
        if (REG_WR && hit(REG_ADDR, `ADDR_KEEP_A)) begin
            nxt_s.keep_a = REG_WDATA;
        end
        if (REG_WR && hit(REG_ADDR, `ADDR_KEEP_B)) begin
            nxt_s.keep_b = REG_WDATA;
        end
        if (REG_WR && hit(REG_ADDR, `ADDR_WIN)) begin
            nxt_s.win = REG_WDATA;
        end
        if (REG_RD) begin
            nxt_s.rdata = read_mux(REG_ADDR, s_ff, act_status, pol_status);
        end
        // Float state is applied through the enables
        nxt_s.data = DATA_IN;
        nxt_s.field = FIELD_IS_ODD ^ s_ff.ctl[`CTL_FLDPOL];
        nxt_s.gsync = GREEN_SYNC_SLICED;
        if (s_ff.cnt_ns <= ~STEP_NS) begin
            nxt_s.cnt_ns = s_ff.cnt_ns + STEP_NS;
        end else begin
            nxt_s.cnt_ns = '1;
        end
        if (raw_fall) begin
            nxt_s.filt = 1'b0;
        end
        case (s_ff.mode)
            FILT_HUNT: begin
                if (raw_rise) begin
                    nxt_s.period_ns = s_ff.cnt_ns;
                    nxt_s.cnt_ns = '0;
                    nxt_s.filt = 1'b1;
                    nxt_s.mode = FILT_LOCKED;
                end
            end
            FILT_LOCKED: begin
                if (raw_rise && in_window) begin
                    nxt_s.period_ns = s_ff.cnt_ns;
                    nxt_s.cnt_ns = '0;
                    nxt_s.filt = 1'b1;
                end else if (late) begin
                    // Missed edge: relearn the line period
                    nxt_s.mode = FILT_HUNT;
                end
            end
            default: begin
                nxt_s.mode = FILT_HUNT;
            end
        endcase
        nxt_s.pll_ref = s_ff.ctl[`CTL_PLLFILT] ? s_ff.filt
                                               : s_ff.pin[`PIN_RAW];
        // The filtered level doubles as the regenerated sync
        nxt_s.sp_sync = s_ff.ctl[`CTL_SPSRC] ? s_ff.filt
                                             : s_ff.pin[`PIN_RAW];
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s_ff <= '0;
            s_ff.ctl <= `CTL_RESET;
            s_ff.keep_a <= KEEP_A_DEFAULT;
            s_ff.keep_b <= KEEP_B_DEFAULT;
            s_ff.win <= `WIN_RESET;
            s_ff.mode <= FILT_HUNT;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign clk_sel = clk_sel_type'(s_ff.ctl[`CTL_CLKSEL_HI:`CTL_CLKSEL_LO]);

    // Glitches on a select change are accepted; software switches while idle
    always_comb begin
        case (clk_sel)
            CK_PIX: CLK_OUT = PIX_CLK;
            CK_PIX90: CLK_OUT = PIX_CLK_90;
            CK_PIX2X: CLK_OUT = PIX_CLK_2X;
            CK_INT40: CLK_OUT = INT_CLK_40M;
            default: CLK_OUT = PIX_CLK;
        endcase
    end

    assign CLK_OUT_OE = ~s_ff.ctl[`CTL_HIZ];
    assign DATA_OE = ~s_ff.ctl[`CTL_HIZ];
    assign FIELD_OE = ~s_ff.ctl[`CTL_HIZ];
    assign GREEN_SYNC_OUTPUT_OE = ~s_ff.ctl[`CTL_SOGHIZ];
    assign DATA_OUT = s_ff.data;
    assign FIELD_OUT = s_ff.field;
    assign GREEN_SYNC_OUTPUT_PIN = s_ff.gsync;
    assign PLL_REF_SYNC = s_ff.pll_ref;
    assign SP_SYNC = s_ff.sp_sync;
    assign REG_RDATA = s_ff.rdata;

    sequence seq_ctl_write(int b, logic v);
        REG_WR && hit(REG_ADDR, `ADDR_CTL) && REG_WDATA[b] == v;
    endsequence

    chk_clock_mux: assert property (
        @(posedge CLK) disable iff (RST)
        (clk_sel == CK_INT40) |-> CLK_OUT == INT_CLK_40M)
        else $error("output clock does not follow select");

    chk_data_float: assert property (
        @(posedge CLK) disable iff (RST)
        seq_ctl_write(`CTL_HIZ, 1'b1) |=> !DATA_OE && !FIELD_OE
            && !CLK_OUT_OE
            && GREEN_SYNC_OUTPUT_OE == !$past(REG_WDATA[`CTL_SOGHIZ]))
        else $error("outputs not floated after write");

    chk_data_drive: assert property (
        @(posedge CLK) disable iff (RST)
        seq_ctl_write(`CTL_HIZ, 1'b0) |=> DATA_OE && FIELD_OE && CLK_OUT_OE)
        else $error("outputs floated while enabled");

    chk_green_float: assert property (
        @(posedge CLK) disable iff (RST)
        seq_ctl_write(`CTL_SOGHIZ, 1'b1) |=> !GREEN_SYNC_OUTPUT_OE)
        else $error("green sync pin not floated");

    chk_green_drive: assert property (
        @(posedge CLK) disable iff (RST)
        seq_ctl_write(`CTL_SOGHIZ, 1'b0) |=> GREEN_SYNC_OUTPUT_OE)
        else $error("green sync pin floated while enabled");

    chk_field_map: assert property (
        @(posedge CLK) disable iff (RST)
        1'b1 |=> FIELD_OUT == ($past(FIELD_IS_ODD)
            ^ $past(s_ff.ctl[`CTL_FLDPOL])))
        else $error("field level does not match polarity");

    chk_pll_source: assert property (
        @(posedge CLK) disable iff (RST)
        s_ff.ctl[`CTL_PLLFILT] |=> PLL_REF_SYNC == $past(s_ff.filt))
        else $error("PLL reference not the filtered sync");

    chk_sp_source: assert property (
        @(posedge CLK) disable iff (RST)
        !s_ff.ctl[`CTL_SPSRC] |=> SP_SYNC == $past(s_ff.pin[`PIN_RAW]))
        else $error("sync processor not on raw sync");

    chk_window_reject: assert property (
        @(posedge CLK) disable iff (RST)
        (s_ff.mode == FILT_LOCKED && raw_rise && !in_window)
            |=> !s_ff.filt)
        else $error("pulse outside window passed");

    chk_window_pass: assert property (
        @(posedge CLK) disable iff (RST)
        (s_ff.mode == FILT_LOCKED && raw_rise && in_window)
            |=> s_ff.filt && s_ff.cnt_ns == '0)
        else $error("pulse inside window rejected");

    chk_activity_read: assert property (
        @(posedge CLK) disable iff (RST)
        (REG_RD && hit(REG_ADDR, `ADDR_ACT)) |=> REG_RDATA == $past(act))
        else $error("activity status read mismatch");

    chk_polarity_read: assert property (
        @(posedge CLK) disable iff (RST)
        (REG_RD && hit(REG_ADDR, `ADDR_POL))
            |=> REG_RDATA[7:3] == $past(pol_status[7:3])
            && REG_RDATA[2:0] == 3'h0)
        else $error("polarity status read mismatch");

endmodule

/* include/sync_ctl_consts.svh */
// Offsets, field positions, reset values and timing figures of the
// sync status and output control block.
// Assumes the 50 MHz internal clock and byte-wide register access.
`ifndef SYNC_CTL_CONSTS_SVH
`define SYNC_CTL_CONSTS_SVH

`define ADDR_CTL 8'h20
`define ADDR_KEEP_A 8'h21
`define ADDR_KEEP_B 8'h22
`define ADDR_WIN 8'h23
`define ADDR_ACT 8'h24
`define ADDR_POL 8'h25

`define CTL_CLKSEL_HI 7
`define CTL_CLKSEL_LO 6
`define CTL_HIZ 5
`define CTL_SOGHIZ 4
`define CTL_FLDPOL 3
`define CTL_PLLFILT 2
`define CTL_SPSRC 1

`define CTL_RESET 8'h08
`define WIN_RESET 8'h0A
`define KEEP_A_RESET 8'h00
`define KEEP_B_RESET 8'h00
`define RD_UNMAPPED 8'h00

// Pin vector index equals the activity status bit
`define PIN_H0 7
`define PIN_H1 6
`define PIN_V0 5
`define PIN_V1 4
`define PIN_EXT 1
`define PIN_RAW 8
`define PIN_COUNT 9
`define SENSE_COUNT 8

`define CLK_PERIOD_NS 20
`define WIN_STEP_NS 25
`define ACT_TIMEOUT_MS 50
`define NS_PER_MS 1000000

`endif

/* include/sync_ctl_pkg.sv */
// Types shared by the sync status and output control design files.
// Assumes nothing beyond a SystemVerilog compiler.
package sync_ctl_pkg;

    typedef enum logic [1:0] {
        CK_PIX = 2'b00,
        CK_PIX90 = 2'b01,
        CK_PIX2X = 2'b10,
        CK_INT40 = 2'b11
    } clk_sel_type;

    typedef enum logic {
        FILT_HUNT = 1'b0,
        FILT_LOCKED = 1'b1
    } filt_mode_type;

endpackage

/* hw/sync_sense.sv */
// Activity and polarity sensing for one synchronised sync level.
// Assumes the level is already in the CLK domain.
`include "sync_ctl_consts.svh"

module sync_sense
    import sync_ctl_pkg::*;
#(
    parameter int CW = 22,
    parameter int TIMEOUT_CYCLES = 2500000
) (
    input wire logic clk,            // Internal clock
    input wire logic rst,            // Synchronous reset
    input wire logic level,          // Synchronised input level
    output logic active,             // Edges seen within timeout
    output logic positive            // High phase shorter than low
);

    typedef struct packed {
        logic prev;
        logic [CW-1:0] idle;
        logic [CW-1:0] run;
        logic [CW-1:0] high_len;
        logic [CW-1:0] low_len;
        logic active;
        logic positive;
    } sense_state_type;

    localparam logic [CW-1:0] IDLE_LAST = CW'(TIMEOUT_CYCLES - 1);
    localparam logic [CW-1:0] ONE = CW'(1);

    sense_state_type s_ff, nxt_s;
    logic edge_seen;

    assign edge_seen = level ^ s_ff.prev;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.prev = level;
        if (s_ff.run != '1) begin
            nxt_s.run = s_ff.run + ONE;
        end
        if (edge_seen) begin
            // Any edge restarts the timeout window
            nxt_s.idle = '0;
            nxt_s.active = 1'b1;
            nxt_s.run = '0;
            if (s_ff.prev) begin
                nxt_s.high_len = s_ff.run;
                // Sync pulses are the short phase
                nxt_s.positive = s_ff.run < s_ff.low_len;
            end else begin
                nxt_s.low_len = s_ff.run;
                nxt_s.positive = s_ff.high_len < s_ff.run;
            end
        end else if (s_ff.idle == IDLE_LAST) begin
            nxt_s.active = 1'b0;
        end else begin
            nxt_s.idle = s_ff.idle + ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign active = s_ff.active;
    assign positive = s_ff.positive;

    chk_edge_sets_active: assert property (
        @(posedge clk) disable iff (rst)
        edge_seen |=> active)
        else $error("activity not flagged after an edge");

    chk_timeout_clears: assert property (
        @(posedge clk) disable iff (rst)
        (!edge_seen && s_ff.idle == IDLE_LAST) |=> !active)
        else $error("activity not cleared at timeout");

endmodule

/* testbench/sync_source_model.sv */
// Model of the incoming video sync pins that the sync block watches.
// Assumes the bench steps one pin at a time; the rest hold their level.
module sync_source_model #(
    parameter logic [7:0] STRAY_AT = 8'h32
) (
    input wire logic clk,          // Bench clock
    input wire logic run,          // Step the selected pin
    input wire logic [3:0] sel,    // Pin index, 8 is the raw sync
    input wire logic [7:0] hi_len, // Cycles high per period
    input wire logic [7:0] period, // Cycles per period
    input wire logic stray,        // Extra pulse mid-period on raw sync
    output logic [8:0] pins,       // Pin levels
    output logic [7:0] phase       // Position within the period
);
    timeunit 1ns;
    timeprecision 1ps;

    logic extra;

    initial begin
        pins = '0;
        phase = '0;
    end

    assign extra = stray && sel == 4'h8 && phase >= STRAY_AT &&
        phase < STRAY_AT + 8'h04;

    // Pins are asynchronous to the chip, so stepping on the falling
    // edge is as good as any phase
    always @(negedge clk) begin
        if (run) begin
            phase <= (phase + 8'h01 >= period) ? 8'h00 : phase + 8'h01;
            // Unselected pins keep their level and so look idle
            pins[sel] <= (phase < hi_len) || extra;
        end
    end
endmodule

/* testbench/sync_status_output_control_test.sv */
// Self-checking bench for the sync status and output control block.
// Assumes the design files and the shared header are compiled first.
`include "sync_ctl_consts.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    n_fail++; $display("unexpected at %0t got %h expected %h", \
    $time, (got), (exp)); end end

module sync_status_output_control_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] REG_ADDR = 8'h00;
    logic [7:0] REG_WDATA = 8'h00;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [7:0] REG_RDATA;
    logic [3:0] cand = 4'h0;
    logic [29:0] data_in = '0;
    logic odd = 1'b0;
    logic sliced = 1'b0;
    logic CLK_OUT, CLK_OUT_OE, DATA_OE, FIELD_OUT, FIELD_OE;
    logic [29:0] DATA_OUT;
    logic GREEN_SYNC_OUTPUT_PIN, GREEN_SYNC_OUTPUT_OE, PLL_REF_SYNC, SP_SYNC;
    logic run = 1'b0;
    logic stray = 1'b0;
    logic [3:0] sel = 4'h8;
    logic [7:0] hi_len = 8'h0A;
    logic [7:0] period = 8'h64;
    logic [8:0] pins;
    logic [7:0] phase;
    logic [7:0] rd_val, ctl, exp_pol;
    logic pos;
    int n_fail = 0;
    int checked = 0;
    int seed_val, i, j, k;

    initial begin
        forever #10 CLK = ~CLK;
    end

    sync_status_output_control #(.TIMEOUT_CYCLES(64)) dut_u (
        .CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
        .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .PIX_CLK(cand[0]), .PIX_CLK_90(cand[1]), .PIX_CLK_2X(cand[2]),
        .INT_CLK_40M(cand[3]), .CLK_OUT(CLK_OUT), .CLK_OUT_OE(CLK_OUT_OE),
        .DATA_IN(data_in), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
        .FIELD_IS_ODD(odd), .FIELD_OUT(FIELD_OUT), .FIELD_OE(FIELD_OE),
        .GREEN_SYNC_SLICED(sliced),
        .GREEN_SYNC_OUTPUT_PIN(GREEN_SYNC_OUTPUT_PIN),
        .GREEN_SYNC_OUTPUT_OE(GREEN_SYNC_OUTPUT_OE),
        .HORIZ_SYNC_IN_CH0(pins[7]), .HORIZ_SYNC_IN_CH1(pins[6]),
        .VERT_SYNC_IN_CH0(pins[5]), .VERT_SYNC_IN_CH1(pins[4]),
        .GREEN_SYNC_IN_CH0(pins[3]), .GREEN_SYNC_IN_CH1(pins[2]),
        .EXT_CLOCK_OR_HOLD_PIN(pins[1]), .CLAMP_PIN(pins[0]),
        .RAW_SYNC(pins[8]), .PLL_REF_SYNC(PLL_REF_SYNC), .SP_SYNC(SP_SYNC)
    );

    sync_source_model src_u (
        .clk(CLK), .run(run), .sel(sel), .hi_len(hi_len), .period(period),
        .stray(stray), .pins(pins), .phase(phase)
    );

    function automatic logic field_exp(input logic o, input logic [7:0] c);
        return o ^ c[`CTL_FLDPOL];
    endfunction

    task automatic summarize();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(negedge CLK);
        REG_WR = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge CLK);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge CLK);
        REG_RD = 1'b0;
        rd_val = REG_RDATA;
    endtask

    // Phase only moves on falling edges, so it is steady at rising ones
    task automatic wait_phase(input logic [7:0] v);
        for (i = 0; i < 300 && phase !== v; i++)
            @(posedge CLK);
        if (phase !== v) begin
            n_fail++;
            summarize();
        end
        #1;
    endtask

    initial begin
        repeat (60000) @(posedge CLK);
        n_fail++;
        summarize();
    end

    initial begin
        seed_val = $urandom(38250);
        repeat (12) @(negedge CLK);
        RST = 1'b0;
        rd(`ADDR_CTL);
        `CHK(rd_val, `CTL_RESET)
        `CHK({CLK_OUT_OE, DATA_OE, GREEN_SYNC_OUTPUT_OE}, 3'h7)
        rd(`ADDR_KEEP_A);
        `CHK(rd_val, `KEEP_A_RESET)
        rd(`ADDR_KEEP_B);
        `CHK(rd_val, `KEEP_B_RESET)
        rd(`ADDR_WIN);
        `CHK(rd_val, `WIN_RESET)
        rd(`ADDR_ACT);
        `CHK(rd_val, 8'h00)
        rd(8'h30);
        `CHK(rd_val, `RD_UNMAPPED)
        ctl = 8'($urandom);
        wr(`ADDR_WIN, ctl);
        rd(`ADDR_WIN);
        `CHK(rd_val, ctl)
        wr(`ADDR_WIN, `WIN_RESET);
        // Every clock selection, with random output-enable and field bits
        for (k = 0; k < 4; k++) begin
            ctl = 8'($urandom);
            ctl[7:6] = k[1:0];
            wr(`ADDR_CTL, ctl);
            rd(`ADDR_CTL);
            `CHK(rd_val, {ctl[7:1], 1'b0})
            `CHK({CLK_OUT_OE, DATA_OE}, {2{~ctl[`CTL_HIZ]}})
            `CHK(FIELD_OE, ~ctl[`CTL_HIZ])
            `CHK(GREEN_SYNC_OUTPUT_OE, ~ctl[`CTL_SOGHIZ])
            for (j = 0; j < 3; j++) begin
                @(negedge CLK);
                cand = 4'($urandom);
                odd = 1'($urandom);
                data_in = 30'($urandom);
                sliced = 1'($urandom);
                #1;
                `CHK(CLK_OUT, cand[ctl[7:6]])
                @(negedge CLK);
                `CHK(FIELD_OUT, field_exp(odd, ctl))
                `CHK(DATA_OUT, data_in)
                `CHK(GREEN_SYNC_OUTPUT_PIN, sliced)
            end
        end
        // Regenerated sync for both consumers, as software is advised to do
        wr(`ADDR_CTL, 8'h06);
        run = 1'b1;
        repeat (500) @(negedge CLK);
        stray = 1'b1;
        wait_phase(8'h07);
        `CHK(PLL_REF_SYNC, 1'b1)
        `CHK(SP_SYNC, 1'b1)
        wait_phase(8'h37);
        `CHK(PLL_REF_SYNC, 1'b0)
        `CHK(SP_SYNC, 1'b0)
        wr(`ADDR_CTL, 8'h00);
        wait_phase(8'h37);
        `CHK(PLL_REF_SYNC, 1'b1)
        `CHK(SP_SYNC, 1'b1)
        run = 1'b0;
        stray = 1'b0;
        exp_pol = 8'h00;
        // One pin at a time, short high phase means positive polarity
        for (k = 0; k < 8; k++) begin
            pos = 1'($urandom);
            sel = k[3:0];
            hi_len = pos ? 8'h03 : 8'h07;
            period = 8'h0A;
            run = 1'b1;
            repeat (40) @(negedge CLK);
            rd(`ADDR_ACT);
            `CHK(rd_val, 8'h01 << k)
            // Bits 7..4 follow the pin index; the hold pin reports in bit 3
            if (k >= `PIN_V1)
                exp_pol[k] = pos;
            if (k == `PIN_EXT)
                exp_pol[3] = pos;
            rd(`ADDR_POL);
            `CHK(rd_val, exp_pol)
            run = 1'b0;
            repeat (100) @(negedge CLK);
            rd(`ADDR_ACT);
            `CHK(rd_val, 8'h00)
        end
        summarize();
    end
endmodule
